//--- rtl/ssr_defines.vh
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH

// register select indices on the status access port
`define SSR_IDX_OPER_COND 4'h0
`define SSR_IDX_OPER_EVENT 4'h1
`define SSR_IDX_OPER_ENABLE 4'h2
`define SSR_IDX_QUAL_COND 4'h3
`define SSR_IDX_QUAL_EVENT 4'h4
`define SSR_IDX_QUAL_ENABLE 4'h5
`define SSR_IDX_STD_COND 4'h6
`define SSR_IDX_STD_EVENT 4'h7
`define SSR_IDX_STD_ENABLE 4'h8
`define SSR_IDX_SRQ_STATUS 4'h9
`define SSR_IDX_SRQ_EVENT 4'ha
`define SSR_IDX_SRQ_ENABLE 4'hb
`define SSR_IDX_ERRQ_COUNT 4'hc

// group widths
`define SSR_WIDE_W 16
`define SSR_NARROW_W 8

// operation bit positions
`define SSR_OP_WAIT_TRIG 5
`define SSR_OP_TRANS_ARMED 6
`define SSR_OP_CONST_VOLT 8
`define SSR_OP_TRANS_DONE 9
`define SSR_OP_CONST_CURR 10
`define SSR_OP_SAMPLE_DONE 11
`define SSR_OP_LIST_DONE 12
`define SSR_OP_LIST_RUN 14
// readable operation condition bits: 5,6,8,10,11,14
`define SSR_OP_COND_MASK 16'h4d60

// quality bit positions
`define SSR_QU_VOLT_MODE_ERR 0
`define SSR_QU_CURR_MODE_ERR 1
`define SSR_QU_THERMAL 3
`define SSR_QU_SLAVE 6
`define SSR_QU_VOLT_PROT 12
`define SSR_QU_CURR_PROT 13
`define SSR_QU_SINKING 14
// readable quality condition bits: 0,1,3,6,12,13,14
`define SSR_QU_COND_MASK 16'h704b

// status byte bit positions
`define SSR_SB_ERR_QUAL 3
`define SSR_SB_MSG_AVAIL 4
`define SSR_SB_STD_SUM 5
`define SSR_SB_RQS 6
`define SSR_SB_OPER_SUM 7

// reset values
`define SSR_RST_16 16'h0000
`define SSR_RST_8 8'h00

// error queue
`define SSR_ERRQ_DEPTH 16
`define SSR_ERRQ_CW 5

`endif

//--- rtl/ssr_group.v
`default_nettype none

module ssr_group #(
    parameter W = 16
) (
    input wire core_clk,
    input wire resetn,
    input wire [W-1:0] cond,
    input wire [W-1:0] pulse_set,
    input wire event_clr,
    input wire enable_wr,
    input wire [W-1:0] enable_wdata,
    input wire enable_clr,
    output reg [W-1:0] event_bits,
    output reg [W-1:0] enable_bits,
    output wire summary
);

    reg [W-1:0] cond_prev;
    wire [W-1:0] rise;
    wire [W-1:0] next_event_bits;

    assign rise = cond & ~cond_prev;
    // set wins over a clear in the same cycle, so no edge is lost
    assign next_event_bits = (event_clr ? {W{1'b0}} : event_bits) | rise | pulse_set;
    assign summary = |(event_bits & enable_bits);

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cond_prev <= {W{1'b0}};
            event_bits <= {W{1'b0}};
            enable_bits <= {W{1'b0}};
        end else begin
            cond_prev <= cond;
            event_bits <= next_event_bits;
            if (enable_clr) begin
                enable_bits <= {W{1'b0}};
            end else if (enable_wr) begin
                enable_bits <= enable_wdata;
            end
        end
    end

endmodule

`default_nettype wire

//--- rtl/ssr_status.v
// Contract
// - status byte bit 3 is one while an error is queued or an enabled quality event is set.
// - status byte bit 4 is set while query response data waits for reading.
// - four groups: operation and quality 16 bits, standard event and request 8.
// - a condition bit rising from zero to one sets its event bit.
// - reading an event register returns it, then clears it; a bit set in the same cycle stays set.
// - operation, quality and standard enable registers gate event bits into the group summary bit.
// - quality event bit 0 enabled asserts status byte bit 3.
// - request bits except 6 are ANDed with enables, ORed into bit 6.
// - the service request line is asserted while request bit 6 is one.
// - a non-empty error queue sets request register bit 3.
// - operation condition bits 0-4, 7, 13, 15 always read zero.
// - operation bit 5 shows trigger enabled, held through a low external trigger.
// - operation bit 6 is one while the transient function is armed.
// - operation bit 8 means constant voltage, bit 10 constant current.
// - operation bits 9 and 12 exist only as events, never as condition.
// - operation bit 11 shows sample complete, bit 14 list running.
// - quality bit 0 means current mode, bit 1 means voltage mode.
// - quality bit 3 is thermal error, bit 6 slave fault.
// - quality bit 12 is voltage protection error, 13 current protection error.
// - with external reference, any protection error sets quality bits 12 and 13.
// - quality bit 14 is one while the unit sinks energy from its load.
// - quality condition bits 2, 4, 5, 7-11, 15 always read zero.
`include "ssr_defines.vh"
`default_nettype none

module ssr_status #(
    parameter ERRQ_DEPTH = `SSR_ERRQ_DEPTH
) (
    input wire core_clk,
    input wire resetn,
    // operation sources, same clock except trig_pin
    input wire trig_enabled,
    input wire trig_source_ext,
    input wire trig_pin,
    input wire trans_armed,
    input wire const_volt,
    input wire const_curr,
    input wire sample_done,
    input wire list_running,
    input wire trans_done_pulse,
    input wire list_done_pulse,
    // quality sources, same clock
    input wire mode_current,
    input wire mode_voltage,
    input wire thermal_err,
    input wire slave_fault,
    input wire volt_prot_err,
    input wire curr_prot_err,
    input wire ext_ref_enabled,
    input wire sinking,
    // standard event sources from the command side
    input wire [`SSR_NARROW_W-1:0] std_cond,
    input wire [`SSR_NARROW_W-1:0] std_pulse,
    // output buffer and error queue
    input wire msg_avail,
    input wire err_push,
    input wire err_pop,
    input wire clear_status,
    input wire preset_enables,
    // register access port
    input wire [3:0] reg_sel,
    input wire reg_rd,
    input wire reg_wr,
    input wire [`SSR_WIDE_W-1:0] reg_wdata,
    output reg [`SSR_WIDE_W-1:0] reg_rdata,
    output reg reg_rvalid,
    // toward the host controller
    output reg [`SSR_NARROW_W-1:0] status_byte,
    output reg srq,
    output reg err_queue_nonempty,
    output reg err_queue_overflow
);

    localparam [31:0] ERRQ_DEPTH_W = ERRQ_DEPTH;
    localparam [`SSR_ERRQ_CW-1:0] ERRQ_MAX = ERRQ_DEPTH_W[`SSR_ERRQ_CW-1:0];
    localparam [`SSR_ERRQ_CW-1:0] ERRQ_ONE = 5'h01;

    // external trigger pin crosses in through two flops
    reg trig_meta;
    reg trig_sync;
    reg trigger_wait_flag;
    reg [`SSR_ERRQ_CW-1:0] errq_count;

    wire next_trigger_wait_flag;
    wire [`SSR_WIDE_W-1:0] oper_cond;
    wire [`SSR_WIDE_W-1:0] oper_pulse;
    wire [`SSR_WIDE_W-1:0] qual_cond;
    wire [`SSR_WIDE_W-1:0] oper_event;
    wire [`SSR_WIDE_W-1:0] oper_enable;
    wire [`SSR_WIDE_W-1:0] qual_event;
    wire [`SSR_WIDE_W-1:0] quality_enable_mask;
    wire [`SSR_NARROW_W-1:0] std_event;
    wire [`SSR_NARROW_W-1:0] std_enable;
    wire [`SSR_NARROW_W-1:0] srq_event;
    wire [`SSR_NARROW_W-1:0] srq_enable;
    wire oper_sum;
    wire qual_sum;
    wire std_sum;
    wire prot_any;
    wire rd_oper_ev;
    wire rd_qual_ev;
    wire rd_std_ev;
    wire rd_srq_ev;
    wire wr_oper_en;
    wire wr_qual_en;
    wire wr_std_en;
    wire wr_srq_en;
    wire next_errq_nonempty;
    wire errq_push_only;
    wire errq_pop_only;
    wire errq_full;
    wire errq_empty;
    wire [`SSR_NARROW_W-1:0] sb_base;
    wire next_rqs;
    wire [`SSR_NARROW_W-1:0] next_status_byte;
    reg [`SSR_WIDE_W-1:0] next_reg_rdata;
    reg [`SSR_ERRQ_CW-1:0] next_errq_count;
    reg next_overflow;

    // pin idles high; both flops reset to it so no false low follows reset
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trig_meta <= 1'b1;
            trig_sync <= 1'b1;
        end else begin
            trig_meta <= trig_pin;
            trig_sync <= trig_meta;
        end
    end

    // hold while the external source is selected and its trigger input is low, even if trigger was disabled
    assign next_trigger_wait_flag = trig_enabled |
        (trig_source_ext & ~trig_sync & trigger_wait_flag);

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trigger_wait_flag <= 1'b0;
        end else begin
            trigger_wait_flag <= next_trigger_wait_flag;
        end
    end

    // operation condition; unused bits tied low
    assign oper_cond[4:0] = 5'h00;
    assign oper_cond[`SSR_OP_WAIT_TRIG] = trigger_wait_flag;
    assign oper_cond[`SSR_OP_TRANS_ARMED] = trans_armed;
    assign oper_cond[7] = 1'b0;
    assign oper_cond[`SSR_OP_CONST_VOLT] = const_volt;
    assign oper_cond[`SSR_OP_TRANS_DONE] = 1'b0;
    assign oper_cond[`SSR_OP_CONST_CURR] = const_curr;
    assign oper_cond[`SSR_OP_SAMPLE_DONE] = sample_done;
    assign oper_cond[`SSR_OP_LIST_DONE] = 1'b0;
    assign oper_cond[13] = 1'b0;
    assign oper_cond[`SSR_OP_LIST_RUN] = list_running;
    assign oper_cond[15] = 1'b0;

    // completion bits reach the event register directly
    assign oper_pulse[8:0] = 9'h000;
    assign oper_pulse[`SSR_OP_TRANS_DONE] = trans_done_pulse;
    assign oper_pulse[11:10] = 2'h0;
    assign oper_pulse[`SSR_OP_LIST_DONE] = list_done_pulse;
    assign oper_pulse[15:13] = 3'h0;

    assign prot_any = volt_prot_err | curr_prot_err;

    assign qual_cond[`SSR_QU_VOLT_MODE_ERR] = mode_current;
    assign qual_cond[`SSR_QU_CURR_MODE_ERR] = mode_voltage;
    assign qual_cond[2] = 1'b0;
    assign qual_cond[`SSR_QU_THERMAL] = thermal_err;
    assign qual_cond[5:4] = 2'h0;
    assign qual_cond[`SSR_QU_SLAVE] = slave_fault;
    assign qual_cond[11:7] = 5'h00;
    assign qual_cond[`SSR_QU_VOLT_PROT] = volt_prot_err | (ext_ref_enabled & prot_any);
    assign qual_cond[`SSR_QU_CURR_PROT] = curr_prot_err | (ext_ref_enabled & prot_any);
    assign qual_cond[`SSR_QU_SINKING] = sinking;
    assign qual_cond[15] = 1'b0;

    // access decode
    assign rd_oper_ev = reg_rd & (reg_sel == `SSR_IDX_OPER_EVENT);
    assign rd_qual_ev = reg_rd & (reg_sel == `SSR_IDX_QUAL_EVENT);
    assign rd_std_ev = reg_rd & (reg_sel == `SSR_IDX_STD_EVENT);
    assign rd_srq_ev = reg_rd & (reg_sel == `SSR_IDX_SRQ_EVENT);
    assign wr_oper_en = reg_wr & (reg_sel == `SSR_IDX_OPER_ENABLE);
    assign wr_qual_en = reg_wr & (reg_sel == `SSR_IDX_QUAL_ENABLE);
    assign wr_std_en = reg_wr & (reg_sel == `SSR_IDX_STD_ENABLE);
    assign wr_srq_en = reg_wr & (reg_sel == `SSR_IDX_SRQ_ENABLE);

    ssr_group #(
        .W(`SSR_WIDE_W)
    ) u_oper (
        .core_clk(core_clk),
        .resetn(resetn),
        .cond(oper_cond),
        .pulse_set(oper_pulse),
        .event_clr(rd_oper_ev | clear_status),
        .enable_wr(wr_oper_en),
        .enable_wdata(reg_wdata),
        .enable_clr(preset_enables),
        .event_bits(oper_event),
        .enable_bits(oper_enable),
        .summary(oper_sum)
    );

    ssr_group #(
        .W(`SSR_WIDE_W)
    ) u_qual (
        .core_clk(core_clk),
        .resetn(resetn),
        .cond(qual_cond),
        .pulse_set(`SSR_RST_16),
        .event_clr(rd_qual_ev | clear_status),
        .enable_wr(wr_qual_en),
        .enable_wdata(reg_wdata),
        .enable_clr(preset_enables),
        .event_bits(qual_event),
        .enable_bits(quality_enable_mask),
        .summary(qual_sum)
    );

    ssr_group #(
        .W(`SSR_NARROW_W)
    ) u_std (
        .core_clk(core_clk),
        .resetn(resetn),
        .cond(std_cond),
        .pulse_set(std_pulse),
        .event_clr(rd_std_ev | clear_status),
        .enable_wr(wr_std_en),
        .enable_wdata(reg_wdata[`SSR_NARROW_W-1:0]),
        .enable_clr(1'b0),
        .event_bits(std_event),
        .enable_bits(std_enable),
        .summary(std_sum)
    );

    ssr_group #(
        .W(`SSR_NARROW_W)
    ) u_srq (
        .core_clk(core_clk),
        .resetn(resetn),
        .cond(status_byte),
        .pulse_set(`SSR_RST_8),
        .event_clr(rd_srq_ev | clear_status),
        .enable_wr(wr_srq_en),
        .enable_wdata(reg_wdata[`SSR_NARROW_W-1:0]),
        .enable_clr(1'b0),
        .event_bits(srq_event),
        .enable_bits(srq_enable),
        .summary()
    );

    // full saturates; further pushes only raise the overflow flag
    assign errq_push_only = err_push & ~err_pop;
    assign errq_pop_only = err_pop & ~err_push;
    assign errq_full = (errq_count == ERRQ_MAX);
    assign errq_empty = (errq_count == {`SSR_ERRQ_CW{1'b0}});

    // error queue tracked as an occupancy count; entries live with the parser
    always @* begin
        next_errq_count = errq_count;
        next_overflow = err_queue_overflow;
        if (clear_status) begin
            next_errq_count = {`SSR_ERRQ_CW{1'b0}};
            next_overflow = 1'b0;
            // a push without a pop in the clearing cycle is kept, so that error is not lost
            if (errq_push_only) begin
                next_errq_count = ERRQ_ONE;
            end
        end else if (errq_push_only) begin
            if (errq_full) begin
                next_overflow = 1'b1;
            end else begin
                next_errq_count = errq_count + ERRQ_ONE;
            end
        end else if (errq_pop_only & ~errq_empty) begin
            next_errq_count = errq_count - ERRQ_ONE;
        end
    end

    assign next_errq_nonempty = (next_errq_count != {`SSR_ERRQ_CW{1'b0}});

    // bit 3 low only when no error is queued and no enabled quality event
    assign sb_base[2:0] = 3'h0;
    assign sb_base[`SSR_SB_ERR_QUAL] = qual_sum | err_queue_nonempty;
    assign sb_base[`SSR_SB_MSG_AVAIL] = msg_avail;
    assign sb_base[`SSR_SB_STD_SUM] = std_sum;
    assign sb_base[`SSR_SB_RQS] = 1'b0;
    assign sb_base[`SSR_SB_OPER_SUM] = oper_sum;
    // bit 6 excluded from its own summary to avoid a loop
    assign next_rqs = |(sb_base & srq_enable & ~(8'h01 << `SSR_SB_RQS));
    assign next_status_byte = sb_base | ({7'h00, next_rqs} << `SSR_SB_RQS);

    always @* begin
        next_reg_rdata = `SSR_RST_16;
        case (reg_sel)
            `SSR_IDX_OPER_COND: next_reg_rdata = oper_cond & `SSR_OP_COND_MASK;
            `SSR_IDX_OPER_EVENT: next_reg_rdata = oper_event;
            `SSR_IDX_OPER_ENABLE: next_reg_rdata = oper_enable;
            `SSR_IDX_QUAL_COND: next_reg_rdata = qual_cond & `SSR_QU_COND_MASK;
            `SSR_IDX_QUAL_EVENT: next_reg_rdata = qual_event;
            `SSR_IDX_QUAL_ENABLE: next_reg_rdata = quality_enable_mask;
            `SSR_IDX_STD_COND: next_reg_rdata = {8'h00, std_cond};
            `SSR_IDX_STD_EVENT: next_reg_rdata = {8'h00, std_event};
            `SSR_IDX_STD_ENABLE: next_reg_rdata = {8'h00, std_enable};
            `SSR_IDX_SRQ_STATUS: next_reg_rdata = {8'h00, status_byte};
            `SSR_IDX_SRQ_EVENT: next_reg_rdata = {8'h00, srq_event};
            `SSR_IDX_SRQ_ENABLE: next_reg_rdata = {8'h00, srq_enable};
            `SSR_IDX_ERRQ_COUNT: next_reg_rdata = {11'h000, errq_count};
            default: next_reg_rdata = `SSR_RST_16;
        endcase
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            errq_count <= {`SSR_ERRQ_CW{1'b0}};
            err_queue_nonempty <= 1'b0;
            err_queue_overflow <= 1'b0;
            status_byte <= `SSR_RST_8;
            srq <= 1'b0;
            reg_rdata <= `SSR_RST_16;
            reg_rvalid <= 1'b0;
        end else begin
            errq_count <= next_errq_count;
            err_queue_nonempty <= next_errq_nonempty;
            err_queue_overflow <= next_overflow;
            status_byte <= next_status_byte;
            srq <= next_rqs;
            reg_rvalid <= reg_rd;
            // data captured before the clear lands
            if (reg_rd) begin
                reg_rdata <= next_reg_rdata;
            end
        end
    end

endmodule

`default_nettype wire

//--- bench/ssr_host.sv
`default_nettype none

module ssr_host (
    input wire logic core_clk,
    output logic [3:0] reg_sel,
    output logic reg_rd,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_sel = 4'h0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
    end

    // idle select and data are inverted so a stale value never passes
    task automatic rd(input logic [3:0] s, output logic [15:0] d);
        @(negedge core_clk);
        reg_sel = s;
        reg_rd = 1'b1;
        @(negedge core_clk);
        // valid and data stand from the edge after the request until the next one
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
        reg_rd = 1'b0;
        reg_sel = ~s;
    endtask

    task automatic wr(input logic [3:0] s, input logic [15:0] w);
        @(negedge core_clk);
        reg_sel = s;
        reg_wdata = w;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_sel = ~s;
        reg_wdata = ~w;
    endtask
endmodule

`default_nettype wire

//--- bench/ssr_status_sva.sv
`default_nettype none

module ssr_status_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic trig_enabled,
    input wire logic msg_avail,
    input wire logic err_push,
    input wire logic err_pop,
    input wire logic clear_status,
    input wire logic [3:0] reg_sel,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [7:0] status_byte,
    input wire logic srq,
    input wire logic err_queue_nonempty
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    a_srq_follows_rqs: assert property (srq == status_byte[6])
        else $error("srq differs from status byte bit 6");
    a_msg_avail_bit: assert property ($past(msg_avail) == msg_avail
        && $past(msg_avail, 2) == msg_avail |-> status_byte[4] == msg_avail)
        else $error("status byte bit 4 does not follow msg_avail");
    a_op_unused_zero: assert property (reg_rvalid && $past(reg_sel) == 4'h0
        |-> (reg_rdata & 16'hb29f) == 16'h0000)
        else $error("unused operation condition bit reads one");
    a_qual_unused_zero: assert property (reg_rvalid && $past(reg_sel) == 4'h3
        |-> (reg_rdata & 16'h8fb4) == 16'h0000)
        else $error("unused quality condition bit reads one");
    a_narrow_high_zero: assert property (reg_rvalid
        && $past(reg_sel) inside {[4'h6:4'hb]} |-> reg_rdata[15:8] == 8'h00)
        else $error("narrow register shows upper bits");
    a_push_nonempty: assert property (err_push && !err_pop && !clear_status
        |=> err_queue_nonempty)
        else $error("push left queue empty");
    a_queue_summary: assert property (err_queue_nonempty |=> status_byte[3])
        else $error("queue entry not summarised in bit 3");
    a_reset_quiet: assert property ($rose(resetn) |-> status_byte == 8'h00
        && !srq && !err_queue_nonempty && !reg_rvalid)
        else $error("outputs not cleared by reset");
    a_trig_flag_set: assert property (reg_rvalid && $past(reg_sel) == 4'h0
        && $past(trig_enabled) && $past(trig_enabled, 2) |-> reg_rdata[5])
        else $error("waiting flag clear while trigger enabled");

    c_srq_raised: cover property ($rose(srq));
    c_qual_event_read: cover property (reg_rvalid && $past(reg_sel) == 4'h4);
    c_bit3_raised: cover property ($rose(status_byte[3]));
endmodule

bind ssr_status ssr_status_sva chk_u (.*);

`default_nettype wire

//--- bench/tb_status_summary_srq.sv
`default_nettype none

module tb_status_summary_srq;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, resetn, trig_enabled, trig_source_ext, trig_pin, trans_armed;
    logic const_volt, const_curr, sample_done, list_running, trans_done_pulse;
    logic list_done_pulse, mode_current, mode_voltage, thermal_err, slave_fault;
    logic volt_prot_err, curr_prot_err, ext_ref_enabled, sinking, msg_avail;
    logic err_push, err_pop, clear_status, preset_enables, reg_rd, reg_wr, reg_rvalid;
    logic srq, err_queue_nonempty, err_queue_overflow;
    logic [7:0] std_cond, std_pulse, status_byte;
    logic [3:0] reg_sel;
    logic [15:0] reg_wdata, reg_rdata;
    int n_errors = 0;
    int total_checks = 0;

    ssr_status #(.ERRQ_DEPTH(4)) dut_u (.*);
    ssr_host host_u (.*);

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic rd_chk(input string what, input logic [3:0] s, input logic [15:0] exp);
        logic [15:0] d;
        host_u.rd(s, d);
        chk(what, exp, d);
    endtask

    task automatic do_reset;
        resetn = 1'b0;
        idle(12);
        resetn = 1'b1;
    endtask

    task automatic t_reset_state;
        logic [3:0] sels[9] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc};
        foreach (sels[i]) rd_chk("cleared reg", sels[i], 16'h0000);
        chk("srq after reset", 16'h0000, 16'(srq));
    endtask

    task automatic t_op;
        trig_enabled = 1'b1;
        {trans_armed, const_volt, const_curr, sample_done, list_running} = 5'h1f;
        {trans_done_pulse, list_done_pulse} = 2'b11;
        idle(1);
        {trans_done_pulse, list_done_pulse} = 2'b00;
        idle(3);
        rd_chk("op cond", 4'h0, 16'h4d60);
        trig_enabled = 1'b0;
        {trans_armed, const_volt, const_curr, sample_done, list_running} = 5'h00;
        idle(4);
        rd_chk("op event", 4'h1, 16'h5f60);
        rd_chk("op event reread", 4'h1, 16'h0000);
    endtask

    // the pin passes a two-flop synchroniser, so waits allow its delay
    task automatic t_trig;
        trig_source_ext = 1'b1;
        trig_enabled = 1'b1;
        idle(2);
        trig_pin = 1'b0;
        idle(4);
        trig_enabled = 1'b0;
        idle(4);
        rd_chk("wait flag held", 4'h0, 16'h0020);
        trig_pin = 1'b1;
        idle(5);
        rd_chk("wait flag released", 4'h0, 16'h0000);
        trig_source_ext = 1'b0;
        rd_chk("op event trig", 4'h1, 16'h0020);
    endtask

    task automatic t_qual;
        {mode_current, mode_voltage, thermal_err, slave_fault} = 4'hf;
        {volt_prot_err, curr_prot_err, sinking} = 3'h7;
        idle(3);
        rd_chk("qual cond", 4'h3, 16'h704b);
        {mode_current, mode_voltage, thermal_err, slave_fault} = 4'h0;
        {volt_prot_err, curr_prot_err, sinking} = 3'h0;
        idle(2);
        ext_ref_enabled = 1'b1;
        volt_prot_err = 1'b1;
        idle(3);
        rd_chk("qual cond ext ref", 4'h3, 16'h3000);
        {ext_ref_enabled, volt_prot_err} = 2'b00;
        rd_chk("qual event", 4'h4, 16'h704b);
        rd_chk("qual event reread", 4'h4, 16'h0000);
    endtask

    task automatic t_srq;
        chk("clean decode bit 3", 16'h0000, 16'(status_byte[3]));
        mode_current = 1'b1;
        idle(3);
        mode_current = 1'b0;
        idle(3);
        chk("masked event bit 3", 16'h0000, 16'(status_byte[3]));
        host_u.wr(4'h5, 16'h0001);
        idle(3);
        chk("enabled event bit 3", 16'h0001, 16'(status_byte[3]));
        chk("srq without enable", 16'h0000, 16'(srq));
        host_u.wr(4'hb, 16'h0008);
        idle(3);
        chk("srq enabled", 16'h0001, 16'(srq));
        rd_chk("qual event clear", 4'h4, 16'h0001);
        idle(3);
        chk("srq after clear", 16'h0000, 16'(srq));
        rd_chk("srq event", 4'ha, 16'h0048);
    endtask

    task automatic t_msg;
        msg_avail = 1'b1;
        idle(3);
        chk("message bit 4", 16'h0001, 16'(status_byte[4]));
        msg_avail = 1'b0;
        idle(3);
        chk("message bit 4 gone", 16'h0000, 16'(status_byte[4]));
    endtask

    task automatic t_errq;
        err_push = 1'b1;
        idle(1);
        err_push = 1'b0;
        idle(3);
        chk("queue bit 3", 16'h0001, 16'(status_byte[3]));
        chk("queue srq", 16'h0001, 16'(srq));
        rd_chk("queue count", 4'hc, 16'h0001);
        err_pop = 1'b1;
        idle(1);
        err_pop = 1'b0;
        idle(3);
        chk("queue empty", 16'h0000, 16'(err_queue_nonempty));
        err_push = 1'b1;
        idle(5);
        err_push = 1'b0;
        chk("queue overflow", 16'h0001, 16'(err_queue_overflow));
        rd_chk("queue full count", 4'hc, 16'h0004);
        clear_status = 1'b1;
        idle(1);
        clear_status = 1'b0;
        idle(1);
        chk("queue cleared", 16'h0000, 16'({err_queue_nonempty, err_queue_overflow}));
    endtask

    task automatic t_sum;
        host_u.wr(4'h8, 16'h0003);
        host_u.wr(4'h2, 16'h0100);
        std_pulse = 8'h01;
        idle(1);
        std_pulse = 8'h00;
        std_cond = 8'h02;
        const_volt = 1'b1;
        idle(4);
        chk("std sum bit 5", 16'h0001, 16'(status_byte[5]));
        chk("oper sum bit 7", 16'h0001, 16'(status_byte[7]));
        rd_chk("std event", 4'h7, 16'h0003);
        preset_enables = 1'b1;
        idle(1);
        preset_enables = 1'b0;
        rd_chk("oper enable preset", 4'h2, 16'h0000);
        idle(3);
        chk("summaries gone", 16'h0000, 16'(status_byte & 8'ha0));
        {std_cond, const_volt} = 9'h000;
    endtask

    initial begin
        resetn = 1'b0;
        trig_pin = 1'b1;
        {trig_enabled, trig_source_ext, trans_armed, const_volt, const_curr} = '0;
        {sample_done, list_running, trans_done_pulse, list_done_pulse} = '0;
        {mode_current, mode_voltage, thermal_err, slave_fault, volt_prot_err} = '0;
        {curr_prot_err, ext_ref_enabled, sinking, msg_avail, err_push, err_pop} = '0;
        {clear_status, preset_enables, std_cond, std_pulse} = '0;
        do_reset();
        t_reset_state();
        t_op();
        t_trig();
        t_qual();
        t_srq();
        t_msg();
        t_sum();
        t_errq();
        // second reset in mid-run must drop the enables written above
        do_reset();
        t_reset_state();
        conclude();
    end

    initial begin
        #50000;
        n_errors++;
        $display("watchdog expired");
        conclude();
    end
endmodule

`default_nettype wire
